// file: rtl/apa_top.sv
// Purpose: Groups the vertex stream into segments and triangles with neighbours
// Assumes: Inputs synchronous to CLOCK; one command per cycle
// Notes:   One primitive at most per cycle, registered on the outputs
`timescale 1ns/10ps
`default_nettype none

module apa_top #(
	parameter int CNT_W = 8
) (
	// Clock, reset, enable
	input  wire logic                    CLOCK,
	input  wire logic                    RST_B,
	input  wire logic                    CE,
	// Command stream
	input  wire apa_pkg::apa_cmd_t       CMD,
	input  wire logic                    TARGET_COMPLETE,
	// Register port
	input  wire logic [7:0]              ADDR,
	input  wire logic [31:0]             WDATA,
	input  wire logic                    WR,
	input  wire logic                    RD,
	output logic      [31:0]             RDATA,
	// Primitive output
	output logic                         PRIM_VALID,
	output apa_pkg::apa_prim_t           PRIM,
	// Status
	output logic      [3:0]              MODE,
	output logic                         ERR_ILLEGAL,
	output logic                         ERR_INCOMPLETE
);

	if (CNT_W < 4)
		$error("CNT_W must be at least 4");

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_ff;
	logic       rst_b;

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
			rst_sync_ff <= 2'h0;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_b = rst_sync_ff[1];

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	apa_pkg::apa_mode_t  mode_ff;
	logic                mark_ff;
	logic [31:0]         ctrl_ff;
	logic                open;
	logic                gs_on;
	logic                c_begin;
	logic                c_end;
	logic                c_vtx;
	logic                c_mark;
	logic                bad_mode;
	logic                err_ill;
	logic                err_inc;
	logic                take_begin;
	logic                take_end;
	logic                take_vtx;

	assign open     = (mode_ff != apa_pkg::MD_NONE);
	assign gs_on    = ctrl_ff[apa_pkg::BIT_GS];
	assign c_begin  = CMD.valid && (CMD.op == apa_pkg::OP_BEGIN);
	assign c_end    = CMD.valid && (CMD.op == apa_pkg::OP_END);
	assign c_vtx    = CMD.valid && (CMD.op == apa_pkg::OP_VERTEX);
	assign c_mark   = CMD.valid && (CMD.op == apa_pkg::OP_MARK);
	assign bad_mode = (CMD.arg[3:0] > apa_pkg::MD_TSTRP_NB) || (CMD.arg[apa_pkg::VTX_W-1:4] != '0);

	// Illegal: nested or bad-mode begin, stray end, other or client command inside a pair
	assign err_ill = CMD.valid && (
		(c_begin && (open || bad_mode)) ||
		(c_end && !open) ||
		(open && ((CMD.op == apa_pkg::OP_OTHER) || (CMD.op == apa_pkg::OP_CLIENT)))
	);
	assign err_inc    = c_begin && !open && !bad_mode && !TARGET_COMPLETE;
	assign take_begin = c_begin && !err_ill && !err_inc;
	assign take_end   = c_end && open;
	assign take_vtx   = c_vtx && open;

	// ----------------------------------------------------------------
	// Mode and boundary mark
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge rst_b)
	begin
		if (!rst_b)
			mode_ff <= apa_pkg::MD_NONE;
		else if (CE && take_begin)
			mode_ff <= apa_pkg::apa_mode_t'(CMD.arg[3:0]);
		else if (CE && take_end)
			mode_ff <= apa_pkg::MD_NONE;
	end

	always_ff @(posedge CLOCK or negedge rst_b)
	begin
		if (!rst_b)
			mark_ff <= 1'b1;
		else if (CE && c_mark)
			mark_ff <= (CMD.arg != '0);
	end

	// ----------------------------------------------------------------
	// Vertex history and counters
	// ----------------------------------------------------------------
	apa_pkg::apa_vtx_t  hist_ff [0:apa_pkg::HIST_D-1];
	apa_pkg::apa_vtx_t  hv      [0:apa_pkg::HIST_D];
	logic [CNT_W-1:0]   cnt_ff;
	logic               wrap_ff;
	logic [2:0]         phase_ff;
	logic [CNT_W-1:0]   nxt_cnt;
	logic               nxt_wrap;

	// Incoming vertex sits at index 0, older ones behind it
	always_comb
	begin
		hv[0].mark = mark_ff;
		hv[0].data = CMD.arg;
		for (int k = 1; k <= apa_pkg::HIST_D; k++)
			hv[k] = hist_ff[k-1];
	end

	assign nxt_cnt  = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
	assign nxt_wrap = wrap_ff || (cnt_ff == {CNT_W{1'b1}});

	always_ff @(posedge CLOCK)
	begin
		if (CE && take_vtx)
			for (int k = 0; k < apa_pkg::HIST_D; k++)
				hist_ff[k] <= hv[k];
	end

	// Counts restart at each accepted begin, from vertex 1
	always_ff @(posedge CLOCK or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_ff   <= '0;
			wrap_ff  <= 1'b0;
			phase_ff <= 3'h0;
		end
		else if (CE && take_begin)
		begin
			cnt_ff   <= '0;
			wrap_ff  <= 1'b0;
			phase_ff <= 3'h0;
		end
		else if (CE && take_vtx)
		begin
			cnt_ff   <= nxt_cnt;
			wrap_ff  <= nxt_wrap;
			phase_ff <= (phase_ff == 3'(apa_pkg::TA_GROUP - 1)) ? 3'h0 : phase_ff + 3'h1;
		end
	end

	function automatic logic at_least(input logic w, input logic [CNT_W-1:0] c, input int x);
		at_least = w || (c >= CNT_W'(x));
	endfunction

	function automatic logic exactly(input logic w, input logic [CNT_W-1:0] c, input int x);
		exactly = !w && (c == CNT_W'(x));
	endfunction

	// ----------------------------------------------------------------
	// Primitive selection
	// ----------------------------------------------------------------
	logic                nxt_valid;
	logic                nxt_seg;
	int                  ix [0:5];
	int                  b;
	apa_pkg::apa_prim_t  nxt_prim;

	always_comb
	begin
		nxt_valid = 1'b0;
		nxt_seg   = 1'b0;
		b         = 0;
		for (int k = 0; k < 6; k++)
			ix[k] = 0;
		if (take_vtx)
		begin
			case (mode_ff)
				apa_pkg::MD_LSTRP_NB:
				begin
					if (at_least(nxt_wrap, nxt_cnt, apa_pkg::SEG_MIN))
					begin
						nxt_valid = 1'b1;
						nxt_seg   = 1'b1;
						ix[0] = 2;
						ix[1] = 1;
						ix[3] = 3;
						ix[4] = 0;
					end
				end
				apa_pkg::MD_TRIS_NB:
				begin
					if (phase_ff == 3'(apa_pkg::TA_GROUP - 1))
					begin
						nxt_valid = 1'b1;
						ix[0] = 5;
						ix[1] = 3;
						ix[2] = 1;
						ix[3] = 4;
						ix[4] = 2;
						ix[5] = 0;
					end
				end
				apa_pkg::MD_TSTRP_NB:
				begin
					// Triangle i leaves when vertex 2i+8 proves it is not last
					if (!nxt_cnt[0] && at_least(nxt_wrap, nxt_cnt, apa_pkg::TSA_FIRST))
					begin
						nxt_valid = 1'b1;
						if (exactly(nxt_wrap, nxt_cnt, apa_pkg::TSA_FIRST))
						begin
							ix[0] = 7; ix[1] = 5; ix[2] = 3;
							ix[3] = 6; ix[4] = 1; ix[5] = 4;
						end
						else if (nxt_cnt[1])
						begin
							ix[0] = 5; ix[1] = 7; ix[2] = 3;
							ix[3] = 9; ix[4] = 4; ix[5] = 1;
						end
						else
						begin
							ix[0] = 7; ix[1] = 5; ix[2] = 3;
							ix[3] = 9; ix[4] = 1; ix[5] = 4;
						end
					end
				end
				default:
				begin
					nxt_valid = 1'b0;
				end
			endcase
		end
		else if (take_end && (mode_ff == apa_pkg::MD_TSTRP_NB) &&
			at_least(wrap_ff, cnt_ff, apa_pkg::TSA_MIN))
		begin
			// hv[b-1] is the last vertex used; an odd count drops the final one
			b = cnt_ff[0] ? 3 : 2;
			nxt_valid = 1'b1;
			if (exactly(wrap_ff, cnt_ff, apa_pkg::TSA_MIN) ||
				exactly(wrap_ff, cnt_ff, apa_pkg::TSA_MIN + 1))
			begin
				ix[0] = b + 4; ix[1] = b + 2; ix[2] = b;
				ix[3] = b + 3; ix[4] = b - 1; ix[5] = b + 1;
			end
			else if (!cnt_ff[1])
			begin
				ix[0] = b + 2; ix[1] = b + 4; ix[2] = b;
				ix[3] = b + 6; ix[4] = b + 1; ix[5] = b - 1;
			end
			else
			begin
				ix[0] = b + 4; ix[1] = b + 2; ix[2] = b;
				ix[3] = b + 6; ix[4] = b - 1; ix[5] = b + 1;
			end
		end
		nxt_prim.seg       = nxt_seg;
		nxt_prim.poly      = !nxt_seg;
		nxt_prim.nbr_valid = gs_on;
		for (int k = 0; k < 3; k++)
		begin
			nxt_prim.corner[k] = hv[ix[k]];
			nxt_prim.nbr[k]    = gs_on ? hv[ix[k+3]] : '0;
		end
		if (nxt_seg)
		begin
			nxt_prim.corner[2] = '0;
			nxt_prim.nbr[2]    = '0;
		end
	end

	// ----------------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge rst_b)
	begin
		if (!rst_b)
		begin
			PRIM_VALID <= 1'b0;
			PRIM       <= '0;
		end
		else if (CE)
		begin
			PRIM_VALID <= nxt_valid;
			if (nxt_valid)
				PRIM <= nxt_prim;
		end
	end

	always_ff @(posedge CLOCK or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ERR_ILLEGAL    <= 1'b0;
			ERR_INCOMPLETE <= 1'b0;
			MODE           <= apa_pkg::MD_NONE;
		end
		else if (CE)
		begin
			ERR_ILLEGAL    <= err_ill;
			ERR_INCOMPLETE <= err_inc;
			MODE           <= (take_begin) ? CMD.arg[3:0] : (take_end ? apa_pkg::MD_NONE : mode_ff);
		end
	end

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	logic [1:0] err_st_ff;
	logic [1:0] err_clr;

	assign err_clr = (WR && (ADDR == apa_pkg::OFS_ERR)) ?
		WDATA[apa_pkg::BIT_E_INC:apa_pkg::BIT_E_ILL] : 2'h0;

	always_ff @(posedge CLOCK or negedge rst_b)
	begin
		if (!rst_b)
			ctrl_ff <= apa_pkg::CTRL_RST;
		else if (CE && WR && (ADDR == apa_pkg::OFS_CTRL))
			ctrl_ff <= {31'h0, WDATA[apa_pkg::BIT_GS]};
	end

	// Hardware set wins over a clear in the same cycle
	always_ff @(posedge CLOCK or negedge rst_b)
	begin
		if (!rst_b)
			err_st_ff <= 2'h0;
		else if (CE)
			err_st_ff <= (err_st_ff & ~err_clr) | {err_inc, err_ill};
	end

	always_ff @(posedge CLOCK or negedge rst_b)
	begin
		if (!rst_b)
			RDATA <= 32'h0;
		else if (CE && RD)
		begin
			case (ADDR)
				apa_pkg::OFS_CTRL:   RDATA <= ctrl_ff;
				apa_pkg::OFS_STATUS: RDATA <= {26'h0, open, mark_ff, mode_ff};
				apa_pkg::OFS_ERR:    RDATA <= {30'h0, err_st_ff};
				default:             RDATA <= 32'h0;
			endcase
		end
		else if (CE)
			RDATA <= 32'h0;
	end

endmodule

`default_nettype wire

// file: rtl/apa_pkg.sv
// Purpose: Shared constants and types of the adjacency primitive assembler
// Assumes: One clock domain; commands arrive one per cycle at most
// Notes:   Mode codes match the begin argument carried on the command port
package apa_pkg;

	// ----------------------------------------------------------------
	// Widths and register map
	// ----------------------------------------------------------------
	localparam int          VTX_W      = 32;
	localparam int          ADDR_W     = 8;
	localparam int          HIST_D     = 9;
	localparam logic [7:0]  OFS_CTRL   = 8'h00;
	localparam logic [7:0]  OFS_STATUS = 8'h04;
	localparam logic [7:0]  OFS_ERR    = 8'h08;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
	localparam int          BIT_GS     = 0;
	localparam int          BIT_E_ILL  = 0;
	localparam int          BIT_E_INC  = 1;
	localparam int          ST_MODE_LO = 0;
	localparam int          ST_MARK    = 4;
	localparam int          ST_OPEN    = 5;

	// ----------------------------------------------------------------
	// Vertex counts that gate assembly
	// ----------------------------------------------------------------
	localparam int SEG_MIN    = 4;
	localparam int TSA_MIN    = 6;
	localparam int TSA_FIRST  = 8;
	localparam int TA_GROUP   = 6;

	// ----------------------------------------------------------------
	// Primitive modes, fifteen values
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		MD_POINTS   = 4'h0,
		MD_LINES    = 4'h1,
		MD_LOOP     = 4'h2,
		MD_LSTRIP   = 4'h3,
		MD_TRIS     = 4'h4,
		MD_TSTRIP   = 4'h5,
		MD_TFAN     = 4'h6,
		MD_QUADS    = 4'h7,
		MD_QSTRIP   = 4'h8,
		MD_POLY     = 4'h9,
		MD_LINES_NB = 4'hA,
		MD_LSTRP_NB = 4'hB,
		MD_TRIS_NB  = 4'hC,
		MD_TSTRP_NB = 4'hD,
		MD_NONE     = 4'hF
	} apa_mode_t;

	// Command classes
	typedef enum logic [2:0] {
		OP_BEGIN  = 3'h0,
		OP_END    = 3'h1,
		OP_VERTEX = 3'h2,
		OP_MARK   = 3'h3,
		OP_ATTR   = 3'h4,
		OP_OTHER  = 3'h5,
		OP_CLIENT = 3'h6
	} apa_op_t;

	typedef struct packed {
		logic             valid;
		apa_op_t          op;
		logic [VTX_W-1:0] arg;
	} apa_cmd_t;

	typedef struct packed {
		logic             mark;
		logic [VTX_W-1:0] data;
	} apa_vtx_t;

	typedef struct packed {
		logic           seg;
		logic           poly;
		logic           nbr_valid;
		apa_vtx_t [2:0] corner;
		apa_vtx_t [2:0] nbr;
	} apa_prim_t;

endpackage

// file: testbench/apa_top_asserts.sv
// Purpose: Temporal checks on the ports of the primitive assembler
// Assumes: Bound to apa_top; CE held high by the bench except in the freeze test
// Notes:   Open pair means MODE differs from the none code
`timescale 1ns/10ps
`default_nettype none
module apa_asserts #(
	parameter int CNT_W = 8
) (
	// Clock and reset
	input wire logic               CLOCK,
	input wire logic               RST_B,
	input wire logic               CE,
	// Command and registers
	input wire apa_pkg::apa_cmd_t  CMD,
	input wire logic               TARGET_COMPLETE,
	input wire logic [7:0]         ADDR,
	input wire logic [31:0]        WDATA,
	input wire logic               WR,
	input wire logic               RD,
	input wire logic [31:0]        RDATA,
	// Outputs
	input wire logic               PRIM_VALID,
	input wire apa_pkg::apa_prim_t PRIM,
	input wire logic [3:0]         MODE,
	input wire logic               ERR_ILLEGAL,
	input wire logic               ERR_INCOMPLETE
);
	logic tk;
	logic op_n;
	logic bg;
	logic en;
	assign tk = CMD.valid && CE;
	assign op_n = MODE != 4'hF;
	assign bg = tk && CMD.op == apa_pkg::OP_BEGIN;
	assign en = tk && CMD.op == apa_pkg::OP_END;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	a_nested_begin: assert property (
		bg && op_n |=> ERR_ILLEGAL && $stable(MODE)) else $error("nested begin not flagged");
	a_end_closed: assert property (
		en && !op_n |=> ERR_ILLEGAL && MODE == 4'hF) else $error("stray end not flagged");
	a_target_incomplete: assert property (
		bg && !op_n && !TARGET_COMPLETE && CMD.arg[3:0] <= 4'hD && CMD.arg[apa_pkg::VTX_W-1:4] == '0
		|=> ERR_INCOMPLETE && MODE == 4'hF)
		else $error("incomplete target not flagged");
	a_begin_opens: assert property (
		bg && !op_n && TARGET_COMPLETE && CMD.arg[3:0] <= 4'hD && CMD.arg[apa_pkg::VTX_W-1:4] == '0
		|=> MODE == $past(CMD.arg[3:0]) && !ERR_ILLEGAL && !ERR_INCOMPLETE) else $error("begin did not open");
	a_foreign_cmd: assert property (
		tk && op_n && CMD.op inside {apa_pkg::OP_OTHER, apa_pkg::OP_CLIENT} |=> ERR_ILLEGAL && $stable(MODE))
		else $error("foreign command not flagged");
	a_legal_cmd: assert property (
		tk && op_n && CMD.op inside {apa_pkg::OP_VERTEX, apa_pkg::OP_MARK, apa_pkg::OP_ATTR} |=> !ERR_ILLEGAL)
		else $error("legal command flagged");
	a_end_closes: assert property (
		en && op_n |=> MODE == 4'hF && !ERR_ILLEGAL) else $error("end did not close");
	a_nbr_dropped: assert property (
		PRIM_VALID && !PRIM.nbr_valid |-> PRIM.nbr == '0) else $error("neighbours not dropped");
	a_mode_values: assert property (
		MODE <= 4'hD || MODE == 4'hF) else $error("mode out of range");
	a_prim_kind: assert property (
		PRIM_VALID |-> PRIM.poly == !PRIM.seg) else $error("primitive kind wrong");
	c_segment: cover property (PRIM_VALID && PRIM.seg);
	c_triangle: cover property (PRIM_VALID && PRIM.poly);
	c_incomplete: cover property (ERR_INCOMPLETE);
endmodule
`default_nettype wire

// file: testbench/apa_sink.sv
// Purpose: Downstream stage model that collects emitted primitives
// Assumes: Each cycle with primitive valid high carries one new primitive
// Notes:   Bench pops the queue in emission order
`timescale 1ns/10ps
`default_nettype none
module apa_sink (
	// Clock and primitive input
	input wire logic               clock,
	input wire logic               prim_valid,
	input wire apa_pkg::apa_prim_t prim
);
	apa_pkg::apa_prim_t q[$];
	always @(posedge clock)
		if (prim_valid === 1'b1)
			q.push_back(prim);
endmodule
`default_nettype wire

// file: testbench/adjacency_primitive_assembler_bench.sv
// Purpose: Self-checking bench of the primitive assembler
// Assumes: CE held high except in t_freeze; vertex payload equals its number
// Notes:   Vertices numbered from mlo onward carry a cleared mark
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t %h %h", $time, a, b); end end
module adjacency_primitive_assembler_bench;
	logic clock, rst_b, ce, tgt, wr, rd, pv, e_ill, e_inc;
	apa_pkg::apa_cmd_t  cmd_s;
	apa_pkg::apa_prim_t prim;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	logic [3:0]  mode;
	int failures = 0, checks = 0, mlo = 99;
	apa_top #(.CNT_W(8)) DUT (.CLOCK(clock), .RST_B(rst_b), .CE(ce), .CMD(cmd_s), .TARGET_COMPLETE(tgt),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PRIM_VALID(pv), .PRIM(prim),
		.MODE(mode), .ERR_ILLEGAL(e_ill), .ERR_INCOMPLETE(e_inc));
	apa_sink sink (.clock(clock), .prim_valid(pv), .prim(prim));
	initial
	begin
		clock = 0;
		forever #4 clock = ~clock;
	end
	// ----------------------------------------------------------------
	// Bus and command helpers
	// ----------------------------------------------------------------
	task cmd(input apa_pkg::apa_op_t op, input logic [31:0] arg);
		@(posedge clock) cmd_s <= {1'b1, op, arg};
	endtask
	task fin();
		@(posedge clock) cmd_s.valid <= 1'b0;
		#1;
	endtask
	task wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock)
		begin
			addr <= a; wdata <= d; wr <= 1'b1;
		end
		@(posedge clock) wr <= 1'b0;
	endtask
	task rreg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock)
		begin
			addr <= a; rd <= 1'b1;
		end
		@(posedge clock) rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask
	function automatic apa_pkg::apa_vtx_t v(input int n);
		v = (n == 0) ? '0 : {1'(n < mlo), 32'(n)};
	endfunction
	function automatic apa_pkg::apa_prim_t pr(input logic s, input int a, b, c, x, y, z);
		pr = {s, !s, 1'b1, v(c), v(b), v(a), v(z), v(y), v(x)};
	endfunction
	task pq(input apa_pkg::apa_prim_t e);
		apa_pkg::apa_prim_t g;
		g = '0;
		if (sink.q.size() > 0) g = sink.q.pop_front();
		`CHK(g, e)
	endtask
	task run(input logic [3:0] m, input int n);
		cmd(apa_pkg::OP_BEGIN, {28'h0, m});
		for (int k = 1; k <= n; k++)
		begin
			if (k == mlo) cmd(apa_pkg::OP_MARK, 32'h0);
			cmd(apa_pkg::OP_VERTEX, 32'(k));
		end
		cmd(apa_pkg::OP_END, 32'h0);
		if (mlo < 99) cmd(apa_pkg::OP_MARK, 32'h5);
		fin();
		repeat (2) @(posedge clock);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_regs();
		rreg(apa_pkg::OFS_CTRL, 32'h1);
		rreg(apa_pkg::OFS_STATUS, 32'h1F);
		wreg(8'h40, 32'hFFFF_FFFF);
		rreg(8'h40, 32'h0);
	endtask
	task t_modes();
		for (int m = 0; m <= 13; m++)
		begin
			cmd(apa_pkg::OP_BEGIN, 32'(m)); fin();
			`CHK(mode, 4'(m))
			cmd(apa_pkg::OP_END, 32'h0); fin();
			`CHK(mode, 4'hF)
		end
		`CHK(sink.q.size(), 0)
	endtask
	task t_errors();
		apa_pkg::apa_op_t ops[4] = '{apa_pkg::OP_ATTR, apa_pkg::OP_MARK, apa_pkg::OP_OTHER, apa_pkg::OP_CLIENT};
		@(posedge clock) tgt <= 1'b0;
		cmd(apa_pkg::OP_BEGIN, 32'hC); fin();
		`CHK({e_inc, mode}, 5'h1F)
		@(posedge clock) tgt <= 1'b1;
		cmd(apa_pkg::OP_END, 32'h0); fin();
		`CHK({e_ill, mode}, 5'h1F)
		cmd(apa_pkg::OP_BEGIN, 32'hE); fin();
		`CHK({e_ill, mode}, 5'h1F)
		cmd(apa_pkg::OP_BEGIN, 32'hD); cmd(apa_pkg::OP_BEGIN, 32'hB); fin();
		`CHK({e_ill, mode}, 5'h1D)
		for (int i = 0; i < 4; i++)
		begin
			cmd(ops[i], 32'h1); fin();
			`CHK({e_ill, mode}, {1'(i >= 2), 4'hD})
		end
		rreg(apa_pkg::OFS_STATUS, 32'h3D);
		cmd(apa_pkg::OP_END, 32'h0); fin();
		rreg(apa_pkg::OFS_ERR, 32'h3);
		wreg(apa_pkg::OFS_ERR, 32'h3);
		rreg(apa_pkg::OFS_ERR, 32'h0);
	endtask
	task t_seg();
		run(4'hB, 3);
		`CHK(sink.q.size(), 0)
		run(4'hB, 5);
		pq(pr(1, 2, 3, 0, 1, 4, 0));
		pq(pr(1, 3, 4, 0, 2, 5, 0));
	endtask
	task t_tris();
		mlo = 7;
		run(4'hC, 13);
		pq(pr(0, 1, 3, 5, 2, 4, 6));
		pq(pr(0, 7, 9, 11, 8, 10, 12));
		`CHK(sink.q.size(), 0)
		mlo = 99;
		rreg(apa_pkg::OFS_STATUS, 32'h1F);
	endtask
	task t_tstrip();
		run(4'hD, 5);
		`CHK(sink.q.size(), 0)
		run(4'hD, 6);
		pq(pr(0, 1, 3, 5, 2, 6, 4));
		run(4'hD, 11);
		pq(pr(0, 1, 3, 5, 2, 7, 4));
		pq(pr(0, 5, 3, 7, 1, 6, 9));
		pq(pr(0, 5, 7, 9, 3, 10, 8));
		run(4'hD, 12);
		pq(pr(0, 1, 3, 5, 2, 7, 4));
		pq(pr(0, 5, 3, 7, 1, 6, 9));
		pq(pr(0, 5, 7, 9, 3, 11, 8));
		pq(pr(0, 9, 7, 11, 5, 10, 12));
		`CHK(sink.q.size(), 0)
	endtask
	task t_nbr();
		apa_pkg::apa_prim_t e;
		wreg(apa_pkg::OFS_CTRL, 32'h0);
		run(4'hC, 6);
		e = pr(0, 1, 3, 5, 0, 0, 0);
		e.nbr_valid = 1'b0;
		pq(e);
		wreg(apa_pkg::OFS_CTRL, 32'h1);
	endtask
	// Commands presented while the clock enable is low must leave no trace
	task t_freeze();
		@(posedge clock) ce <= 1'b0;
		cmd(apa_pkg::OP_BEGIN, 32'hB);
		cmd(apa_pkg::OP_MARK, 32'h0);
		fin();
		`CHK(mode, 4'hF)
		@(posedge clock) ce <= 1'b1;
		rreg(apa_pkg::OFS_STATUS, 32'h1F);
		`CHK(sink.q.size(), 0)
	endtask
	task finish_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		rst_b = 0; ce = 1; tgt = 1; wr = 0; rd = 0; addr = '0; wdata = '0; cmd_s = '0;
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		repeat (3) @(posedge clock);
		t_regs();
		t_modes();
		t_errors();
		t_seg();
		t_tris();
		t_tstrip();
		t_nbr();
		t_freeze();
		finish_test();
	end
	initial
	begin
		#40000;
		failures++;
		finish_test();
	end
endmodule
bind apa_top apa_asserts #(.CNT_W(CNT_W)) CHKR (.CLOCK(CLOCK), .RST_B(RST_B), .CE(CE), .CMD(CMD),
	.TARGET_COMPLETE(TARGET_COMPLETE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
	.PRIM_VALID(PRIM_VALID), .PRIM(PRIM), .MODE(MODE), .ERR_ILLEGAL(ERR_ILLEGAL),
	.ERR_INCOMPLETE(ERR_INCOMPLETE));
`default_nettype wire
